// *** dv/tb_top.sv ***
// tb_top: self-checking bench for pmrc_top with a register model
// assumes 40 MHz clk_sys, register map of pmrc_pkg, WAKE_CYC cut to 16

module tb_top
  import pmrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned WAKE = 16;

  logic              clk_sys, rst_n, bus_wr, bus_rd, ext_reset_pin;
  logic              ext_irq_pin_0, ext_irq_pin_1, irq_pending;
  logic              wdt_overflow, low_supply_detector, nv_boot_select;
  logic              low_supply_flash_protect, low_supply_reset_enable;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0]        bus_wdata, bus_rdata_q;
  logic              core_clk_en_q, periph_clk_en_q, osc_stop_q;
  logic              adc_power_off_q, dev_reset_q, boot_isp_q;
  logic              flash_block_q, low_supply_irq_q;
  logic [1:0]        wake_src_q;
  int                error_cnt, n_tests, rst_seen, pwr_m, div_m, aux_m;
  int                fpc_m, i, s, m, cnt, r0;
  logic [7:0]        g;

  pmrc_top #(.WAKE_CYC(WAKE)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata_q(bus_rdata_q), .ext_reset_pin(ext_reset_pin),
    .ext_irq_pin_0(ext_irq_pin_0), .ext_irq_pin_1(ext_irq_pin_1),
    .irq_pending(irq_pending), .wdt_overflow(wdt_overflow),
    .low_supply_detector(low_supply_detector),
    .nv_boot_select(nv_boot_select),
    .low_supply_flash_protect(low_supply_flash_protect),
    .low_supply_reset_enable(low_supply_reset_enable),
    .core_clk_en_q(core_clk_en_q), .periph_clk_en_q(periph_clk_en_q),
    .osc_stop_q(osc_stop_q), .adc_power_off_q(adc_power_off_q),
    .dev_reset_q(dev_reset_q), .boot_isp_q(boot_isp_q),
    .flash_block_q(flash_block_q), .low_supply_irq_q(low_supply_irq_q),
    .wake_src_q(wake_src_q)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (dev_reset_q === 1'b1) begin
      rst_seen <= rst_seen + 1;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    // model: idle dropped when both mode bits are set
    case (a)
      ADR_PWR: pwr_m = d[1] ? (d & 8'hBE) : (d & 8'hBF);
      ADR_DIV: div_m = d & 8'h07;
      ADR_AUX: aux_m = d & 8'h04;
      ADR_FPC: fpc_m = d & 8'hC0;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input int exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata_q, exp[15:0]);
  endtask : rd

  // internal reset keeps low-supply and power-on flags, flash enable and soft boot; general flags clear
  task automatic int_rst();
    pwr_m = pwr_m & 8'h30;
    div_m = 0;
    aux_m = 0;
  endtask : int_rst

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, bus_wr, bus_rd, ext_reset_pin, ext_irq_pin_0} = '0;
    {ext_irq_pin_1, irq_pending, wdt_overflow, low_supply_detector} = '0;
    {bus_addr, bus_wdata, low_supply_flash_protect} = '0;
    {nv_boot_select, low_supply_reset_enable} = 2'b11;
    {error_cnt, n_tests, rst_seen} = '0;
    {pwr_m, fpc_m, div_m, aux_m} = {32'h30, 32'h40, 64'h0};
    g = 8'($urandom(90173));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(3);
    rd(ADR_PWR, pwr_m);
    rd(ADR_FPC, fpc_m);
    chk(boot_isp_q, 1);
    wr(ADR_PWR, 8'h4C);
    rd(ADR_PWR, pwr_m);
    rd(3'h5, 0);
    for (s = 0; s < 8; s++) begin
      g = 8'($urandom) & 8'h8C;
      wr(ADR_DIV, 8'(s));
      wr(ADR_PWR, g | 8'h01);
      cyc(3);
      chk(core_clk_en_q, 0);
      chk(adc_power_off_q, 1);
      cnt = 0;
      for (i = 0; i < 256; i++) begin
        cyc(1);
        cnt += int'(periph_clk_en_q);
      end
      chk(cnt, 256 >> s);
      @(posedge clk_sys);
      irq_pending <= 1'b1;
      @(posedge clk_sys);
      irq_pending <= 1'b0;
      cyc(2);
      chk({core_clk_en_q, periph_clk_en_q}, 2'b11);
      pwr_m = g;
      rd(ADR_PWR, pwr_m);
    end
    wr(ADR_PWR, g | 8'h03);
    cyc(3);
    chk({osc_stop_q, core_clk_en_q}, 2'b10);
    chk(adc_power_off_q, 1);
    rd(ADR_PWR, pwr_m);
    rd(ADR_DIV, div_m);
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    repeat (6) @(posedge clk_sys);
    irq_pending <= 1'b0;
    cyc(2);
    chk(osc_stop_q, 1);
    @(posedge clk_sys);
    ext_irq_pin_1 <= 1'b1;
    @(posedge clk_sys);
    ext_irq_pin_1 <= 1'b0;
    for (i = 0; i < 40 && core_clk_en_q !== 1'b1; i++) begin
      cyc(1);
    end
    if (core_clk_en_q !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    chk(i >= WAKE && i <= WAKE + 2, 1);
    chk(wake_src_q, 2'b10);
    pwr_m = g;
    rd(ADR_PWR, pwr_m);
    wr(ADR_PWR, 8'h02);
    cyc(3);
    @(posedge clk_sys);
    ext_irq_pin_0 <= 1'b1;
    @(posedge clk_sys);
    ext_irq_pin_0 <= 1'b0;
    cyc(WAKE - 4);
    chk(core_clk_en_q, 0);
    cyc(6);
    chk({core_clk_en_q, wake_src_q}, 3'b101);
    pwr_m = 0;
    // a pulse one cycle short of the minimum must be ignored
    r0 = rst_seen;
    @(posedge clk_sys);
    ext_reset_pin <= 1'b1;
    repeat (RST_MIN_CYC - 1) @(posedge clk_sys);
    ext_reset_pin <= 1'b0;
    cyc(3);
    chk(rst_seen, r0);
    for (m = 1; m < 3; m++) begin
      wr(ADR_PWR, 8'(m));
      cyc(3);
      @(posedge clk_sys);
      ext_reset_pin <= 1'b1;
      repeat (RST_MIN_CYC + 4) @(posedge clk_sys);
      #1;
      chk(dev_reset_q, 1);
      ext_reset_pin <= 1'b0;
      cyc(3);
      chk({dev_reset_q, core_clk_en_q, osc_stop_q}, 3'b010);
      int_rst();
      rd(ADR_PWR, pwr_m);
      rd(ADR_DIV, div_m);
    end
    nv_boot_select <= 1'b0;
    wr(ADR_AUX, 8'h04);
    r0 = rst_seen;
    wr(ADR_FPC, 8'hE0);
    cyc(4);
    chk(rst_seen - r0, 1);
    int_rst();
    chk(boot_isp_q, 1);
    rd(ADR_FPC, fpc_m);
    rd(ADR_AUX, aux_m);
    r0 = rst_seen;
    @(posedge clk_sys);
    wdt_overflow <= 1'b1;
    @(posedge clk_sys);
    wdt_overflow <= 1'b0;
    cyc(3);
    chk(rst_seen - r0, 1);
    wr(ADR_AUX, 8'h04);
    @(posedge clk_sys);
    low_supply_detector <= 1'b1;
    cyc(3);
    pwr_m = pwr_m | 8'h20;
    rd(ADR_PWR, pwr_m);
    chk(flash_block_q, 1);
    chk(low_supply_irq_q, 1);
    low_supply_detector <= 1'b0;
    cyc(3);
    chk(flash_block_q, 0);
    rd(ADR_PWR, pwr_m);
    wr(ADR_PWR, 8'h00);
    cyc(2);
    chk(low_supply_irq_q, 0);
    low_supply_reset_enable <= 1'b0;
    low_supply_flash_protect <= 1'b1;
    @(posedge clk_sys);
    low_supply_detector <= 1'b1;
    cyc(12);
    chk(dev_reset_q, 1);
    chk(flash_block_q, 0);
    low_supply_detector <= 1'b0;
    cyc(3);
    chk(dev_reset_q, 0);
    // second power-up: flags return, flash enable and boot bit clear
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n <= 1'b1;
    cyc(3);
    pwr_m = 32'h30;
    fpc_m = 0;
    rd(ADR_PWR, pwr_m);
    rd(ADR_FPC, fpc_m);
    chk(boot_isp_q, 0);
    complete_run();
  end

endmodule : tb_top

// *** inc/pmrc_pkg.sv ***
// pmrc_pkg: constants, types and register layout for power_mode_reset_control
// assumes a 40 MHz system clock and an 8-bit register port

package pmrc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RST_MIN_NS    = 10_000;
  localparam int unsigned RST_EXTRA_CYC = 36;
  // least time: round up to whole cycles
  localparam int unsigned RST_MIN_CYC   =
    (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + RST_EXTRA_CYC;
  localparam int unsigned RST_CNT_W     = 9;
  localparam logic [RST_CNT_W-1:0] RST_MIN_CNT = RST_CNT_W'(RST_MIN_CYC);
  localparam int unsigned WAKE_CYC_DEF  = 32768;
  localparam int unsigned WAKE_CNT_W    = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 3;
  localparam logic [ADDR_W-1:0] ADR_PWR = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_DIV = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_AUX = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_FPC = 3'h3;

  localparam int unsigned DIV_SEL_W    = 3;
  localparam int unsigned DIV_CNT_W    = 7;
  localparam int unsigned AUX_LVI_BIT  = 2;
  localparam int unsigned FPC_EN_BIT   = 7;
  localparam int unsigned FPC_BOOT_BIT = 6;
  localparam int unsigned FPC_SWR_BIT  = 5;
  localparam int unsigned PWR_PD_BIT   = 1;
  localparam int unsigned PWR_IDL_BIT  = 0;

  localparam logic [7:0] PWR_RST = 8'h30;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef struct packed {
    logic serial_rate_double;
    logic reserved_zero_bit;
    logic low_supply_flag;
    logic power_on_flag;
    logic general_flag_1;
    logic general_flag_0;
    logic powerdown_request_bit;
    logic idle_request_bit;
  } pmrc_pwr_t;

  typedef struct packed {
    logic                 flash_prog_enable;
    logic                 soft_boot_select;
  } pmrc_fpc_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_IDLE = 2'b01,
    ST_PDN  = 2'b10,
    ST_WARM = 2'b11
  } pmrc_state_t;

endpackage : pmrc_pkg

// *** rtl/pmrc_top.sv ***
// pmrc_top: idle / power-down sequencing, idle clock divider, supply and
// power-on flags, reset source merge and boot entrance select.
// assumes clk_sys keeps ticking for this block while osc_stop_q stops the
// oscillator for the rest of the chip; wake and irq inputs are pre-enabled.
//
// Overview of operation
// - idle bit stops core clock, peripheral clocks keep running
// - enabled interrupt during idle clears idle bit, ends idle
// - reset pin high during idle gives internal reset, ends idle
// - idle clock divided by 1..128 per 3-bit code; full rate after
// - power-down bit stops oscillator, keeps register contents
// - power-down left only by any reset source or external irq pins
// - reset pin wake from power-down restarts at address zero
// - irq pin wake withholds core clock 32768 cycles, then resumes
// - idle or power-down switches converter power off
// - supply falling below threshold sets sticky low-supply flag
// - low-supply flag is set by power-up
// - low-supply flag with enable raises interrupt request
// - protect option zero blocks flash access while supply low
// - reset option zero holds device in reset while supply low
// - power-on flag set at power-up, kept until software clears
// - reserved power bit reads zero, writes ignored
// - reset from power-up, pin, watchdog, low supply, software
// - power-up copies nonvolatile boot bit into soft boot bit
// - other resets keep current soft boot bit for entrance
// - reset pin must stay high 10us plus 36 cycles; shorter ignored
// - soft reset bit write triggers device reset
// - soft reset keeps flash enable and soft boot bits
//
// The address-and-strobe port and the register addresses were chosen for this implementation.

module pmrc_top
  import pmrc_pkg::*;
#(
  parameter int unsigned WAKE_CYC = WAKE_CYC_DEF
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]        bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [7:0]        bus_rdata_q,
  input  wire logic              ext_reset_pin,
  input  wire logic              ext_irq_pin_0,
  input  wire logic              ext_irq_pin_1,
  input  wire logic              irq_pending,
  input  wire logic              wdt_overflow,
  input  wire logic              low_supply_detector,
  input  wire logic              nv_boot_select,
  input  wire logic              low_supply_flash_protect,
  input  wire logic              low_supply_reset_enable,
  output logic                   core_clk_en_q,
  output logic                   periph_clk_en_q,
  output logic                   osc_stop_q,
  output logic                   adc_power_off_q,
  output logic                   dev_reset_q,
  output logic                   boot_isp_q,
  output logic                   flash_block_q,
  output logic                   low_supply_irq_q,
  output logic      [1:0]        wake_src_q
);

  localparam logic [WAKE_CNT_W-1:0] WAKE_MAX = WAKE_CNT_W'(WAKE_CYC - 1);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_s_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic [RST_CNT_W-1:0] rpin_cnt_q, rpin_cnt_d;
  logic                 lvd_q;
  logic                 soft_reset_trigger_q, soft_reset_trigger_d;
  logic                 pin_rst, lvr, int_rst, lv_fall;
  logic                 wr_pwr, wr_div, wr_aux, wr_fpc;

  assign wr_pwr = bus_wr && (bus_addr == ADR_PWR);
  assign wr_div = bus_wr && (bus_addr == ADR_DIV);
  assign wr_aux = bus_wr && (bus_addr == ADR_AUX);
  assign wr_fpc = bus_wr && (bus_addr == ADR_FPC);

  always_comb begin
    rpin_cnt_d = '0;
    if (ext_reset_pin) begin
      rpin_cnt_d = (rpin_cnt_q == RST_MIN_CNT) ? rpin_cnt_q
                                               : rpin_cnt_q + 1'b1;
    end
    soft_reset_trigger_d = wr_fpc && bus_wdata[FPC_SWR_BIT];
  end

  // short glitches never reach the count, so they cause nothing
  assign pin_rst = ext_reset_pin
                   && (rpin_cnt_q >= RST_MIN_CNT - 1'b1);
  assign lvr     = low_supply_detector
                   && !low_supply_reset_enable;
  assign int_rst = pin_rst || wdt_overflow || lvr || soft_reset_trigger_q;
  assign lv_fall = low_supply_detector && !lvd_q;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rpin_cnt_q <= '0;
      lvd_q      <= 1'b0;
      soft_reset_trigger_q    <= 1'b0;
    end else begin
      rpin_cnt_q <= rpin_cnt_d;
      lvd_q      <= low_supply_detector;
      soft_reset_trigger_q    <= soft_reset_trigger_d;
    end
  end

  // ----------------------------------------------------------------
  // registers and mode sequencer
  // ----------------------------------------------------------------
  pmrc_pwr_t             pwr_q, pwr_d;
  logic [DIV_SEL_W-1:0]  div_q, div_d;
  logic                  lvi_en_q, lvi_en_d;
  pmrc_fpc_t             fpc_q, fpc_d;
  logic                  boot_load_q;
  pmrc_state_t           state_q, state_d;
  logic [WAKE_CNT_W-1:0] wake_cnt_q, wake_cnt_d;
  logic [1:0]            wake_src_d;
  logic                  pin_wake;

  assign pin_wake = ext_irq_pin_0 || ext_irq_pin_1;

  always_comb begin
    pwr_d      = pwr_q;
    div_d      = div_q;
    lvi_en_d   = lvi_en_q;
    fpc_d      = fpc_q;
    state_d    = state_q;
    wake_cnt_d = '0;
    wake_src_d = wake_src_q;
    if (wr_pwr && (state_q == ST_RUN)) begin
      pwr_d = pmrc_pwr_t'(bus_wdata);
      pwr_d.reserved_zero_bit = 1'b0;
      if (bus_wdata[PWR_PD_BIT]) begin
        pwr_d.idle_request_bit = 1'b0;
      end
    end
    if (wr_div) begin
      div_d = bus_wdata[DIV_SEL_W-1:0];
    end
    if (wr_aux) begin
      lvi_en_d = bus_wdata[AUX_LVI_BIT];
    end
    if (wr_fpc) begin
      fpc_d.flash_prog_enable = bus_wdata[FPC_EN_BIT];
      fpc_d.soft_boot_select  = bus_wdata[FPC_BOOT_BIT];
    end
    case (state_q)
      ST_RUN: begin
        if (pwr_q.powerdown_request_bit) begin
          state_d    = ST_PDN;
          wake_src_d = 2'b00;
        end else if (pwr_q.idle_request_bit) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          pwr_d.idle_request_bit = 1'b0;
          state_d = ST_RUN;
        end
      end
      ST_PDN: begin
        if (pin_wake) begin
          pwr_d.powerdown_request_bit = 1'b0;
          wake_src_d = {ext_irq_pin_1, ext_irq_pin_0};
          state_d    = ST_WARM;
        end
      end
      ST_WARM: begin
        // unstable oscillator: core held until the count expires
        if (wake_cnt_q == WAKE_MAX) begin
          state_d = ST_RUN;
        end else begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
    if (int_rst) begin
      // warm reset: low-supply and power-on flags, flash enable and boot select survive; general flags clear
      pwr_d = pmrc_pwr_t'({2'b00, pwr_q.low_supply_flag,
                           pwr_q.power_on_flag, 4'h0});
      div_d      = '0;
      lvi_en_d   = 1'b0;
      fpc_d      = fpc_q;
      state_d    = ST_RUN;
      wake_cnt_d = '0;
      wake_src_d = 2'b00;
    end
    // after the reset merge: a reset source live at release cannot mask it
    if (boot_load_q) begin
      fpc_d.soft_boot_select = nv_boot_select;
    end
    if (lv_fall) begin
      pwr_d.low_supply_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pwr_q       <= pmrc_pwr_t'(PWR_RST);
      div_q       <= '0;
      lvi_en_q    <= 1'b0;
      fpc_q       <= '0;
      boot_load_q <= 1'b1;
      state_q     <= ST_RUN;
      wake_cnt_q  <= '0;
      wake_src_q  <= 2'b00;
    end else begin
      pwr_q       <= pwr_d;
      div_q       <= div_d;
      lvi_en_q    <= lvi_en_d;
      fpc_q       <= fpc_d;
      boot_load_q <= 1'b0;
      state_q     <= state_d;
      wake_cnt_q  <= wake_cnt_d;
      wake_src_q  <= wake_src_d;
    end
  end

  // ----------------------------------------------------------------
  // idle divider and outputs
  // ----------------------------------------------------------------
  logic [DIV_CNT_W-1:0] div_cnt_q, div_cnt_d, div_mask;
  logic                 tick;
  logic [7:0]           rdata_d;

  always_comb begin
    div_mask  = DIV_CNT_W'((8'h01 << div_q) - 8'h01);
    div_cnt_d = (state_d == ST_IDLE) ? div_cnt_q + 1'b1 : '0;
    tick      = ((div_cnt_d & div_mask) == '0);
    rdata_d   = 8'h00;
    if (!bus_rd) begin
      rdata_d = 8'h00;
    end else if (bus_addr == ADR_PWR) begin
      rdata_d = pwr_q;
    end else if (bus_addr == ADR_DIV) begin
      rdata_d = {5'h00, div_q};
    end else if (bus_addr == ADR_AUX) begin
      rdata_d = 8'(lvi_en_q) << AUX_LVI_BIT;
    end else if (bus_addr == ADR_FPC) begin
      rdata_d = {fpc_q, 6'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      div_cnt_q        <= '0;
      bus_rdata_q      <= 8'h00;
      core_clk_en_q    <= 1'b1;
      periph_clk_en_q  <= 1'b1;
      osc_stop_q       <= 1'b0;
      adc_power_off_q  <= 1'b0;
      dev_reset_q      <= 1'b0;
      boot_isp_q       <= 1'b0;
      flash_block_q    <= 1'b0;
      low_supply_irq_q <= 1'b0;
    end else begin
      div_cnt_q        <= div_cnt_d;
      bus_rdata_q      <= rdata_d;
      core_clk_en_q    <= (state_d == ST_RUN);
      periph_clk_en_q  <= (state_d == ST_RUN)
                          || ((state_d == ST_IDLE) && tick);
      osc_stop_q       <= (state_d == ST_PDN);
      adc_power_off_q  <= (state_d != ST_RUN);
      dev_reset_q      <= int_rst;
      boot_isp_q       <= fpc_d.soft_boot_select;
      flash_block_q    <= low_supply_detector
                          && !low_supply_flash_protect;
      low_supply_irq_q <= pwr_d.low_supply_flag && lvi_en_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_s_n);

  idle_gate_a: assert property (
    (state_q == ST_IDLE) |-> !core_clk_en_q && adc_power_off_q)
    else $error("core clock or converter on in idle");
  idle_wake_a: assert property (
    (state_q == ST_IDLE && irq_pending && !int_rst)
    |=> (state_q == ST_RUN) && !pwr_q.idle_request_bit ##1 core_clk_en_q)
    else $error("idle not ended by interrupt");
  pin_reset_a: assert property (
    (ext_reset_pin && rpin_cnt_q == RST_MIN_CNT - 1'b1)
    |=> dev_reset_q && (state_q == ST_RUN))
    else $error("long reset pulse missed");
  pin_short_a: assert property (
    (!ext_reset_pin ##1 (ext_reset_pin && !wdt_overflow && !lvr
     && !soft_reset_trigger_q)[*8]) |=> !dev_reset_q)
    else $error("short reset pulse accepted");
  div_half_a: assert property (
    (state_q == ST_IDLE && div_q == 3'h1 && periph_clk_en_q)
    ##1 (state_q == ST_IDLE) |-> !periph_clk_en_q)
    else $error("divide by two wrong");
  run_full_a: assert property (
    (state_q == ST_RUN) |-> periph_clk_en_q && core_clk_en_q)
    else $error("clock divided outside idle");
  pdn_hold_a: assert property (
    (state_q == ST_PDN && !int_rst && !pin_wake) |=> state_q == ST_PDN
    && osc_stop_q)
    else $error("power-down left without cause");
  warm_wait_a: assert property (
    $rose(state_q == ST_WARM) |-> !core_clk_en_q[*8])
    else $error("core clock released early");
  warm_end_a: assert property (
    (state_q == ST_WARM && wake_cnt_q == WAKE_MAX && !int_rst)
    |=> core_clk_en_q)
    else $error("core clock not released after count");
  pd_clear_a: assert property (
    (state_q == ST_PDN && pin_wake && !int_rst)
    |=> !pwr_q.powerdown_request_bit && wake_src_q != 2'b00)
    else $error("power-down bit kept after wake");
  lvf_set_a: assert property (
    lv_fall |=> pwr_q.low_supply_flag
    && (low_supply_irq_q == lvi_en_q))
    else $error("low-supply flag not set");
  rsv_zero_a: assert property (
    bus_rd && bus_addr == ADR_PWR |=> !bus_rdata_q[6])
    else $error("reserved bit reads one");
  soft_reset_trigger_a: assert property (
    (wr_fpc && bus_wdata[FPC_SWR_BIT]) |-> ##2 dev_reset_q)
    else $error("soft reset missed");
  both_pd_a: assert property (
    (state_q == ST_RUN && wr_pwr && bus_wdata[1:0] == 2'b11 && !int_rst)
    |=> pwr_q.powerdown_request_bit && !pwr_q.idle_request_bit)
    else $error("idle and power-down not merged");
  // option pins are levels: checks look one edge later
  flash_prot_a: assert property (
    (low_supply_detector && !low_supply_flash_protect)
    |=> flash_block_q)
    else $error("flash left open on low supply");
  low_rst_a: assert property (
    (low_supply_detector && !low_supply_reset_enable)
    |=> dev_reset_q && (state_q == ST_RUN))
    else $error("low supply did not hold reset");
  boot_load_a: assert property (
    boot_load_q
    |=> fpc_q.soft_boot_select == $past(nv_boot_select))
    else $error("boot bit not loaded at power-up");
  boot_keep_a: assert property (
    (int_rst && !boot_load_q)
    |=> $stable(fpc_q))
    else $error("warm reset changed boot or enable bit");
  pdn_off_a: assert property (
    (state_q == ST_PDN || state_q == ST_WARM)
    |-> adc_power_off_q && !core_clk_en_q && !periph_clk_en_q)
    else $error("clock or converter on in power-down");

  idle_c: cover property (state_q == ST_IDLE ##1 state_q == ST_RUN);
  warm_c: cover property (state_q == ST_PDN ##1 state_q == ST_WARM);
  pinrst_c: cover property (state_q == ST_PDN && pin_rst);
  lvf_c: cover property (lv_fall && lvi_en_q);
  lvr_c: cover property (lvr ##1 dev_reset_q);

endmodule : pmrc_top
